//--- hw/fops_defines.vh
// Purpose: Constants for the flash operation status word logic
// Assumes: 50 MHz system clock
// Notes:   Times are in microseconds; cycle counts derive from them
`ifndef FOPS_DEFINES_VH
`define FOPS_DEFINES_VH

// Status word field positions
`define FOPS_BIT_POLL      7
`define FOPS_BIT_TOG1      6
`define FOPS_BIT_ERR       5
`define FOPS_BIT_WIN       3
`define FOPS_BIT_TOG2      2
// Bit of the written word mirrored by the poll bit
`define FOPS_DATA_POLL_SRC 7

// Reset values
`define FOPS_TOG1_RST      1'b0
`define FOPS_TOG2_RST      1'b0
`define FOPS_ERR_RST       1'b0
`define FOPS_WORD_RST      16'h0000

// Timing
`define FOPS_CLK_MHZ       50
`define FOPS_WIN_US        96
`define FOPS_PROT_US       100
`define FOPS_WIN_CYC       (`FOPS_WIN_US * `FOPS_CLK_MHZ)
`define FOPS_PROT_CYC      (`FOPS_PROT_US * `FOPS_CLK_MHZ)
`define FOPS_TMR_W         16

`endif

//--- hw/fops_timer.v
// Purpose: Down counter that pulses once when a loaded interval runs out
// Assumes: Load value of at least one cycle
// Notes:   A new load restarts the interval; abort stops it silently;
//          the end pulse does not look at load, so a caller may reload on it
`timescale 1ns/10ps
module fops_timer
#(
   parameter W = 16
)
(
   input  wire         clock,     // System clock
   input  wire         rst_b,     // Async reset, active low
   input  wire         load,      // Start interval
   input  wire         abort,     // Stop interval
   input  wire [W-1:0] load_val,  // Interval in cycles
   output wire         expired,   // One-cycle end pulse
   output wire         running    // Interval in progress
);

reg [W-1:0] cnt_ff;
reg         run_ff;

////////////////////////////////////////////////////////////////////////////////
// Count down while running
always @(posedge clock or negedge rst_b)
begin
   if (!rst_b)
   begin
      cnt_ff <= {W{1'b0}};
      run_ff <= 1'b0;
   end
   else if (load)
   begin
      cnt_ff <= load_val;
      run_ff <= 1'b1;
   end
   else if (abort)
   begin
      run_ff <= 1'b0;
   end
   else if (run_ff)
   begin
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      if (cnt_ff == {{(W-1){1'b0}}, 1'b1})
         run_ff <= 1'b0;
   end
end

// End of interval
assign expired = run_ff && !abort && (cnt_ff == {{(W-1){1'b0}}, 1'b1});
assign running = run_ff;

endmodule

//--- hw/fops_status.v
// Purpose: Status word returned by flash reads while the controller works
// Assumes: Controller events are one-cycle pulses; reads are one-cycle strobes
// Notes:   rd_data is valid the cycle after rd_strobe
//
// Notes on behaviour
// - Programming shows inverted bit 7 of written word, true bit after finish.
// - Erase shows poll bit 0, then 1 when erase completes.
// - All targets protected: poll bit 0 for about 100 us, then array data.
// - Erase suspend entry moves poll bit from 0 to 1.
// - Program during suspend shows poll bit as a normal program does.
// - Toggle bit flips on every status read while program or erase runs.
// - Two equal toggle reads mean done; the second of them gives the final poll bit.
// - Read of an erase-suspended block forces primary toggle bit to 1.
// - Suspend and resume commands each flip the primary toggle bit.
// - Error bit set when program, block erase or chip erase fails.
// - Error bit set when programming tries to turn a 0 into 1.
// - While busy, every flash read returns the status bits instead of array.
// - Error bit stays set until the read/reset command clears it.
// - Erase window bit reads 0 from last erase command until 96 us pass.
`timescale 1ns/10ps
`include "fops_defines.vh"
module fops_status
#(
   parameter WIN_CYC  = `FOPS_WIN_CYC,   // Erase start window in cycles
   parameter PROT_CYC = `FOPS_PROT_CYC   // Protected erase hold in cycles
)
(
   input  wire        clock,            // System clock
   input  wire        rst_b,            // Async reset, active low
   input  wire        prog_start,       // Word program command accepted
   input  wire [15:0] prog_data,        // Word being programmed
   input  wire [15:0] prog_old_data,    // Word currently stored there
   input  wire        erase_cmd,        // Last block erase command accepted
   input  wire        erase_all_prot,   // Every target block is protected
   input  wire        op_done,          // Program or erase finished
   input  wire        op_fail,          // Program or erase failed
   input  wire        suspend_cmd,      // Erase suspend command
   input  wire        resume_cmd,       // Erase resume command
   input  wire        read_reset_cmd,   // Read/reset command
   input  wire        rd_strobe,        // Flash read cycle
   input  wire        rd_susp_block,    // Read targets the suspended block
   input  wire [15:0] array_data,       // Array word at read address
   output wire        erase_go,         // Start the erase pulse
   output wire        busy,             // Controller busy
   output wire        in_suspend,       // Erase suspend mode
   output reg  [15:0] rd_data           // Read data, registered
);

// Sequencer states
localparam ST_IDLE  = 3'd0;
localparam ST_PROG  = 3'd1;
localparam ST_WIN   = 3'd2;
localparam ST_ERASE = 3'd3;
localparam ST_PROT  = 3'd4;
localparam ST_SUSP  = 3'd5;
localparam ST_SPROG = 3'd6;
localparam ST_DONE  = 3'd7;

localparam [`FOPS_TMR_W-1:0] WIN_LD  = WIN_CYC[`FOPS_TMR_W-1:0];
localparam [`FOPS_TMR_W-1:0] PROT_LD = PROT_CYC[`FOPS_TMR_W-1:0];

reg  [2:0]  state_ff;
reg  [2:0]  nxt_state;
reg         last_prog_ff;      // Last operation was a program
reg         poll_src_ff;       // Bit 7 of word programmed
reg         tog1_ff;
reg         tog2_ff;
reg         err_ff;
reg         tmr_load;
reg  [`FOPS_TMR_W-1:0] tmr_val;
wire        tmr_exp;
reg         status_rd;
reg  [15:0] nxt_rd;
reg         poll;
reg         tog1_out;
reg         prog_err;
reg         prog_take;         // Program command taken
reg         erase_take;        // Erase command taken

////////////////////////////////////////////////////////////////////////////////
// Status word packing, unused bits zero
function [15:0] fops_pack;
   input p;
   input t1;
   input e;
   input w;
   input t2;
   begin
      fops_pack = `FOPS_WORD_RST;
      fops_pack[`FOPS_BIT_POLL] = p;
      fops_pack[`FOPS_BIT_TOG1] = t1;
      fops_pack[`FOPS_BIT_ERR]  = e;
      fops_pack[`FOPS_BIT_WIN]  = w;
      fops_pack[`FOPS_BIT_TOG2] = t2;
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Shared interval timer for erase window and protected hold
fops_timer #(.W(`FOPS_TMR_W)) u_tmr
(
   .clock    (clock),
   .rst_b    (rst_b),
   .load     (tmr_load),
   .abort    (1'b0),
   .load_val (tmr_val),
   .expired  (tmr_exp),
   .running  ()
);

////////////////////////////////////////////////////////////////////////////////
// Next state and timer loads
always @*
begin
   nxt_state = state_ff;
   tmr_load  = 1'b0;
   tmr_val   = WIN_LD;
   case (state_ff)
      ST_IDLE, ST_DONE:
      begin
         if (prog_start)
            nxt_state = ST_PROG;
         else if (erase_cmd)
         begin
            nxt_state = ST_WIN;
            tmr_load  = 1'b1;
         end
         else if (state_ff == ST_DONE && rd_strobe)
            nxt_state = ST_IDLE;
      end
      ST_PROG, ST_ERASE:
      begin
         if (op_done || op_fail)
            nxt_state = ST_DONE;
         else if (state_ff == ST_ERASE && suspend_cmd)
            nxt_state = ST_SUSP;
      end
      ST_WIN:
      begin
         if (erase_cmd)
            tmr_load = 1'b1;
         else if (tmr_exp && erase_all_prot)
         begin
            nxt_state = ST_PROT;
            tmr_load  = 1'b1;
            tmr_val   = PROT_LD;
         end
         else if (tmr_exp)
            nxt_state = ST_ERASE;
      end
      ST_PROT:
      begin
         if (tmr_exp)
            nxt_state = ST_IDLE;
      end
      ST_SUSP:
      begin
         if (resume_cmd)
            nxt_state = ST_ERASE;
         else if (prog_start)
            nxt_state = ST_SPROG;
      end
      ST_SPROG:
      begin
         if (op_done || op_fail)
            nxt_state = ST_SUSP;
      end
      default:
         nxt_state = ST_IDLE;
   endcase
end

// Erase pulse starts when the window closes with an unprotected target
assign erase_go   = (state_ff == ST_WIN) && tmr_exp && !erase_cmd && !erase_all_prot;
assign busy       = (state_ff == ST_PROG) || (state_ff == ST_WIN) ||
                    (state_ff == ST_ERASE) || (state_ff == ST_PROT) ||
                    (state_ff == ST_SPROG);
assign in_suspend = (state_ff == ST_SUSP) || (state_ff == ST_SPROG);

////////////////////////////////////////////////////////////////////////////////
// Read steering and status bit values
always @*
begin
   status_rd = 1'b0;
   poll      = 1'b1;
   tog1_out  = tog1_ff;
   if (state_ff == ST_PROG || state_ff == ST_SPROG)
   begin
      status_rd = 1'b1;
      poll      = ~poll_src_ff;
   end
   else if (state_ff == ST_WIN || state_ff == ST_ERASE || state_ff == ST_PROT)
   begin
      status_rd = 1'b1;
      poll      = 1'b0;
   end
   else if (state_ff == ST_DONE)
   begin
      status_rd = 1'b1;
      poll      = last_prog_ff ? poll_src_ff : 1'b1;
      tog1_out  = ~tog1_ff;
   end
   else if (state_ff == ST_SUSP && rd_susp_block)
   begin
      status_rd = 1'b1;
      poll      = 1'b1;
      tog1_out  = 1'b1;
   end
   if (status_rd)
      nxt_rd = fops_pack(poll, tog1_out, err_ff, state_ff != ST_WIN, tog2_ff);
   else
      nxt_rd = array_data;
end

// Commands count where the sequencer takes them, plus a program that meets a resume in suspend; a 0 to 1 program is an error
always @*
begin
   prog_take  = prog_start && ((state_ff == ST_IDLE) || (state_ff == ST_DONE) ||
                               (state_ff == ST_SUSP));
   erase_take = erase_cmd && !prog_start && ((state_ff == ST_IDLE) || (state_ff == ST_DONE));
   prog_err   = prog_take && ((prog_data & ~prog_old_data) != 16'h0000);
end

////////////////////////////////////////////////////////////////////////////////
// Registered state, toggles, error and read data
always @(posedge clock or negedge rst_b)
begin
   if (!rst_b)
   begin
      state_ff     <= ST_IDLE;
      last_prog_ff <= 1'b0;
      poll_src_ff  <= 1'b0;
      tog1_ff      <= `FOPS_TOG1_RST;
      tog2_ff      <= `FOPS_TOG2_RST;
      err_ff       <= `FOPS_ERR_RST;
      rd_data      <= `FOPS_WORD_RST;
   end
   else
   begin
      state_ff <= nxt_state;
      // A program inside suspend must not hide the erase result
      if (prog_take)
      begin
         if (state_ff != ST_SUSP)
            last_prog_ff <= 1'b1;
         poll_src_ff  <= prog_data[`FOPS_DATA_POLL_SRC];
      end
      else if (erase_take)
         last_prog_ff <= 1'b0;
      // Primary toggle: flips on suspend or resume, otherwise per busy read
      if ((state_ff == ST_ERASE && suspend_cmd) || (state_ff == ST_SUSP && resume_cmd))
         tog1_ff <= ~tog1_ff;
      else if (rd_strobe && busy)
         tog1_ff <= ~tog1_ff;
      // Secondary toggle: erase reads and suspended block reads
      if (rd_strobe && ((state_ff == ST_ERASE) || (in_suspend && rd_susp_block)))
         tog2_ff <= ~tog2_ff;
      // Sticky error, a new failure wins over the clear
      if (op_fail || prog_err)
         err_ff <= 1'b1;
      else if (read_reset_cmd)
         err_ff <= 1'b0;
      if (rd_strobe)
         rd_data <= nxt_rd;
   end
end

endmodule

//--- testbench/fops_status_sva.sv
// Purpose: Port assertions for the flash operation status word block
// Assumes: Reader holds program data and protection steady around checks
// Notes:   Bound into every fops_status instance
`timescale 1ns/10ps
module fops_status_sva
#(
   parameter WIN_CYC = 8   // Erase start window in cycles
)
(
   input wire        clock,          // System clock
   input wire        rst_b,          // Async reset, active low
   input wire        prog_start,     // Program accepted
   input wire [15:0] prog_data,      // Word programmed
   input wire [15:0] prog_old_data,  // Word stored
   input wire        erase_cmd,      // Erase accepted
   input wire        erase_all_prot, // Targets protected
   input wire        resume_cmd,     // Erase resume
   input wire        rd_strobe,      // Read cycle
   input wire        rd_susp_block,  // Suspended block read
   input wire        erase_go,       // Erase pulse start
   input wire        busy,           // Controller busy
   input wire        in_suspend,     // Suspend mode
   input wire [15:0] rd_data         // Read data
);
   localparam int WL = WIN_CYC;
   localparam int WH = WIN_CYC + 1;
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   // Read data, status field and erase start checks
   hold_data_a: assert property (!rd_strobe |=> $stable(rd_data))
      else $error("read data moved without a read");
   reserved_zero_a: assert property (rd_strobe && busy |=> (rd_data & 16'hFF13) == 16'h0000)
      else $error("reserved status bits not zero");
   window_len_a: assert property (erase_cmd && !busy && !in_suspend && !erase_all_prot
      |-> ##[WL:WH] erase_go)
      else $error("erase start not at window end");
   window_bit_a: assert property (erase_cmd && !busy && !in_suspend ##1 rd_strobe
      |=> rd_data[7] == 1'b0 && rd_data[3] == 1'b0)
      else $error("window read wrong");
   erase_poll_a: assert property (erase_go ##1 rd_strobe
      |=> rd_data[7] == 1'b0 && rd_data[3] == 1'b1)
      else $error("erase read wrong");
   toggle_flip_a: assert property ((rd_strobe && busy) ##1 !rd_strobe ##1 (rd_strobe && busy)
      |=> rd_data[6] != $past(rd_data[6], 2))
      else $error("toggle bit did not flip");
   prog_err_a: assert property (prog_start && !busy && !in_suspend
      && (prog_data & ~prog_old_data) != 16'h0000 ##1 rd_strobe |=> rd_data[5])
      else $error("error bit not set on zero to one");
   susp_read_a: assert property (rd_strobe && rd_susp_block && in_suspend && !busy
      && !resume_cmd && !prog_start |=> rd_data[7:6] == 2'b11)
      else $error("suspended block read wrong");
endmodule
bind fops_status fops_status_sva #(.WIN_CYC(WIN_CYC)) u_fops_status_sva (.*);

//--- testbench/fops_cpu.sv
// Purpose: Reader model issuing flash read cycles
// Assumes: Tasks are entered at a falling clock edge
// Notes:   Block select and array word show the inverse pattern outside reads
`timescale 1ns/10ps
module fops_cpu
(
   input  wire        clock,         // System clock
   input  wire [15:0] rd_data,       // Read data
   output reg         rd_strobe,     // Read cycle
   output reg         rd_susp_block, // Suspended block read
   output reg  [15:0] array_data     // Array word
);
   initial
   begin
      rd_strobe = 1'b0;
      rd_susp_block = 1'b0;
      array_data = 16'h0000;
   end
   // One read cycle then one idle cycle
   task rd(input sb, input [15:0] arr, output [15:0] q);
   begin
      rd_strobe = 1'b1;
      rd_susp_block = sb;
      array_data = arr;
      @(negedge clock);
      rd_strobe = 1'b0;
      rd_susp_block = ~sb;
      array_data = ~arr;
      q = rd_data;
      @(negedge clock);
   end
   endtask
endmodule

//--- testbench/test_fops_status.sv
// Purpose: Self-checking bench for the flash operation status word block
// Assumes: Shortened window and protected hold counts
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/10ps
module test_fops_status;
   reg         clock;     // System clock
   reg         rst_b;     // Reset, active low
   reg  [6:0]  ev;        // Event pulses
   reg  [15:0] pd;        // Word to program
   reg  [15:0] po;        // Word stored
   reg         prot;      // Targets protected
   wire        erase_go;  // Erase start
   wire        busy;      // Busy level
   wire        in_susp;   // Suspend mode
   wire        rs;        // Read strobe
   wire        sb;        // Suspended block read
   wire [15:0] ad;        // Array word
   wire [15:0] rd_data;   // Read data
   reg  [15:0] q;         // Last read
   reg  [15:0] q0;        // Earlier read
   integer     error_cnt; // Mismatches
   integer     n_checks;  // Comparisons
   integer     cyc;       // Cycle count
   integer     i;         // Wait index
   fops_status #(.WIN_CYC(8), .PROT_CYC(10)) u_fops_status (.clock(clock), .rst_b(rst_b),
      .prog_start(ev[0]), .prog_data(pd), .prog_old_data(po), .erase_cmd(ev[1]),
      .erase_all_prot(prot), .op_done(ev[2]), .op_fail(ev[3]), .suspend_cmd(ev[4]),
      .resume_cmd(ev[5]), .read_reset_cmd(ev[6]), .rd_strobe(rs), .rd_susp_block(sb),
      .array_data(ad), .erase_go(erase_go), .busy(busy), .in_suspend(in_susp),
      .rd_data(rd_data));
   fops_cpu u_fops_cpu (.clock(clock), .rd_data(rd_data), .rd_strobe(rs),
      .rd_susp_block(sb), .array_data(ad));
   always #10 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   // Masked word compare
   task cmp(input [15:0] got, input [15:0] exp, input [15:0] msk);
   begin
      n_checks = n_checks + 1;
      if ((got & msk) !== (exp & msk))
      begin
         error_cnt = error_cnt + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   // One-cycle event pulse
   task evp(input [6:0] m);
   begin
      ev = m;
      @(negedge clock);
      ev = 7'h00;
   end
   endtask
   task final_report;
   begin
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   // Hang guard
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt = error_cnt + 1;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      clock = 1'b0;
      rst_b = 1'b0;
      ev = 7'h00;
      pd = 16'h0080;
      po = 16'hFFFF;
      prot = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      cyc = 0;
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
      u_fops_cpu.rd(1'b0, 16'h1234, q);
      cmp(q, 16'h1234, 16'hFFFF);
      evp(7'h01);
      u_fops_cpu.rd(1'b0, 16'h5555, q0);
      cmp(q0, 16'h0008, 16'hFFBF);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, {q0[15:7], ~q0[6], q0[5:0]}, 16'hFFFF);
      evp(7'h04);
      u_fops_cpu.rd(1'b0, 16'h5555, q0);
      cmp(q0, {8'h00, 1'b1, q[6], 6'h08}, 16'hFFFF);
      u_fops_cpu.rd(1'b0, 16'h0000, q);
      pd = 16'h0001;
      po = 16'h0000;
      evp(7'h01);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h00A8, 16'hFFBF);
      evp(7'h40);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0088, 16'hFFBF);
      evp(7'h08);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0020, 16'h0020);
      u_fops_cpu.rd(1'b0, 16'h0000, q);
      evp(7'h40);
      @(negedge clock);
      evp(7'h02);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0000, 16'hFFBB);
      for (i = 0; i < 20 && erase_go !== 1'b1; i = i + 1)
         @(negedge clock);
      cmp({15'h0000, erase_go}, 16'h0001, 16'h0001);
      @(negedge clock);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0008, 16'hFFBB);
      evp(7'h10);
      u_fops_cpu.rd(1'b1, 16'h5555, q);
      cmp(q, 16'h00C0, 16'hFFC0);
      u_fops_cpu.rd(1'b0, 16'hABCD, q);
      cmp(q, 16'hABCD, 16'hFFFF);
      pd = 16'h0000;
      po = 16'hFFFF;
      evp(7'h01);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0080, 16'h0080);
      evp(7'h04);
      cmp({15'h0000, in_susp}, 16'h0001, 16'h0001);
      cmp({15'h0000, busy}, 16'h0000, 16'h0001);
      @(negedge clock);
      evp(7'h20);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0008, 16'h00A8);
      evp(7'h04);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0088, 16'hFFBB);
      u_fops_cpu.rd(1'b0, 16'h0000, q);
      prot = 1'b1;
      evp(7'h02);
      repeat (12) @(negedge clock);
      u_fops_cpu.rd(1'b0, 16'h5555, q);
      cmp(q, 16'h0008, 16'hFFBB);
      repeat (10) @(negedge clock);
      cmp({15'h0000, busy}, 16'h0000, 16'h0001);
      u_fops_cpu.rd(1'b0, 16'h0F0F, q);
      cmp(q, 16'h0F0F, 16'hFFFF);
      final_report;
   end
endmodule
